/* File: acz_autozero.sv */
`include "acz_map.svh"
`default_nettype none

module acz_autozero (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // strobe events and pins
    input wire logic strobe_rise,
    input wire logic strobe_fall,
    input wire logic autozero,
    input wire logic first_done,
    input wire logic output_format_select,
    input wire logic [15:0] raw,
    // results
    output logic [15:0] code,
    output logic [15:0] offset_q,
    output logic offset_valid_q,
    output logic armed_q
);
    logic capture;

    // saturating signed difference, then output coding
    function automatic logic [15:0] acz_format(input logic [15:0] v, input logic [15:0] off, input logic ob);
        logic signed [17:0] d;
        logic signed [17:0] r;
        d = 18'(signed'(v)) - 18'(signed'(off));
        if (d > 18'sh07FFF) begin
            d = 18'sh07FFF;
        end else if (d < -18'sh08000) begin
            d = -18'sh08000;
        end
        if (ob) begin
            r = 18'sh08000 - d;
            if (r > 18'sh0FFFF) begin
                r = 18'sh0FFFF;
            end else if (r < 18'sh0) begin
                r = 18'sh0;
            end
            acz_format = r[15:0];
        end else begin
            acz_format = ~d[15:0];
        end
    endfunction

    assign capture = strobe_rise && armed_q && autozero;

    always_comb begin
        if (capture || !offset_valid_q) begin
            code = acz_format(raw, 16'h0000, output_format_select);
        end else begin
            code = acz_format(raw, offset_q, output_format_select);
        end
    end

    // ==========================================================
    // arming, capture and clear
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            armed_q <= 1'b0;
        end else if (capture) begin
            armed_q <= 1'b0;
        end else if (strobe_fall && !autozero && first_done) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            offset_q <= 16'h0000;
            offset_valid_q <= 1'b0;
        end else if (!autozero) begin
            offset_q <= 16'h0000;
            offset_valid_q <= 1'b0;
        end else if (capture) begin
            offset_q <= raw;
            offset_valid_q <= 1'b1;
        end
    end
endmodule

`default_nettype wire

/* File: acz_cal_engine.sv */
`include "acz_map.svh"
`default_nettype none

module acz_cal_engine #(
    parameter int CAL_TICKS = `ACZ_CAL_TICKS,
    parameter int WORDS = `ACZ_CAL_WORDS
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // control
    input wire logic tick,
    input wire logic start,
    input wire logic [15:0] trim_sample,
    input wire logic [$clog2(WORDS)-1:0] rd_index,
    // status
    output logic busy,
    output logic done,
    output logic codes_valid,
    output logic [15:0] rd_word
);
    localparam int CW = $clog2(CAL_TICKS + 1);
    localparam int IW = $clog2(WORDS);

    if (CAL_TICKS < WORDS || WORDS < 2) begin
        $error("acz_cal_engine: CAL_TICKS must cover WORDS, WORDS >= 2");
    end

    // ==========================================================
    // correction store: volatile, deliberately no reset on the array
    logic [15:0] codes [WORDS];
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            busy <= 1'b0;
            cnt_q <= '0;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy <= 1'b1;
                cnt_q <= '0;
            end else if (busy && tick) begin
                if (cnt_q == CW'(CAL_TICKS - 1)) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (busy && tick) begin
            codes[cnt_q[IW-1:0]] <= trim_sample ^ 16'(cnt_q);
        end
    end

    // codes are lost with power: valid only after a full pass since reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            codes_valid <= 1'b0;
        end else if (start && !busy) begin
            codes_valid <= 1'b0;
        end else if (done) begin
            codes_valid <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        rd_word <= codes[rd_index];
    end
endmodule

`default_nettype wire

/* File: acz_ctrl.sv */
`include "acz_map.svh"
`default_nettype none

// What this block does
// - Correction codes live in volatile storage and are lost at power-down.
// - Calibration is requested any time by pulling the request pin low.
// - Request during a conversion waits; calibration starts right after it ends.
// - Idle converter starts calibration on the first edge after the request.
// - Calibration request always beats a conversion request.
// - Calibration status is high from cycle start until cycle completion.
// - Request pulses while status is high are ignored.
// - A calibration lasts about 15 ms at nominal clock, scaling with clock.
// - 17 clock periods of recovery follow every calibration before conversions.
// - Conversion requests are ignored during the recovery interval.
// - Request held low repeats calibration cycles back to back without limit.
// - On release, finish current calibration, wait 17 periods, resume conversions.
// - Autozero stores a zeroing result and subtracts it from later results.
// - After nulling, zero input reads all ones, or midscale in offset binary.
// - Offset latched on first strobe rise after autozero high, shown on bus.
// - Later results stay corrected while autozero stays high.
// - Autozero low clears the offset and results revert to uncorrected.
// - Autozero cannot arm before the first conversion after power-up completes.
// - Format select low: complementary twos complement; high: complementary offset binary.
// - Output arithmetic saturates the difference to the signed 16-bit range before coding.
// - Conversion starts on first edge after start seen high, raising hold command.
module acz_ctrl #(
    parameter int CAL_TICKS = `ACZ_CAL_TICKS,
    parameter int TICK_DIV = `ACZ_TICK_DIV,
    parameter int RECOVER_TICKS = `ACZ_RECOVER_TICKS,
    parameter int HOLD_TICKS = `ACZ_HOLD_TICKS,
    parameter int TAIL_TICKS = `ACZ_TAIL_TICKS,
    parameter int STROBE_TICKS = `ACZ_STROBE_TICKS,
    parameter int CAL_WORDS = `ACZ_CAL_WORDS
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // converter control pins
    input wire logic cal_req_n,
    input wire logic start_convert,
    input wire logic autozero,
    input wire logic output_format_select,
    // analog front end samples
    input wire logic [15:0] sample_data,
    input wire logic [15:0] trim_sample,
    // converter outputs
    output logic cal_status_q,
    output logic hold_cmd_q,
    output logic data_strobe_q,
    output logic [15:0] data_out_q,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata_q
);
    localparam int TW = $clog2(TICK_DIV + 1);
    localparam int PW = 6;
    localparam int IW = $clog2(CAL_WORDS);
    localparam logic [31:0] CTRL_RESET = `ACZ_CTRL_RESET;

    if (TICK_DIV < 1 || CAL_TICKS < 1 || RECOVER_TICKS < 1 || HOLD_TICKS < 1) begin
        $error("acz_ctrl: timing parameters must be at least one");
    end
    if (TAIL_TICKS < 1 || STROBE_TICKS < 1 || STROBE_TICKS >= HOLD_TICKS + TAIL_TICKS) begin
        $error("acz_ctrl: strobe must fit inside one conversion");
    end
    if (HOLD_TICKS + TAIL_TICKS >= 2 ** PW || RECOVER_TICKS >= 2 ** PW) begin
        $error("acz_ctrl: phase counter too narrow");
    end

    // ==========================================================
    // conversion clock enable
    logic [TW-1:0] div_q;
    logic tick_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else if (div_q == TW'(TICK_DIV - 1)) begin
            div_q <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ==========================================================
    // software control
    logic soft_cal_q;
    logic conv_en_q;
    logic [31:0] cal_count_q;
    logic [IW-1:0] cal_index_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            soft_cal_q <= 1'b0;
            conv_en_q <= CTRL_RESET[`ACZ_CTRL_CONV_EN];
            cal_index_q <= '0;
        end else begin
            soft_cal_q <= 1'b0;
            if (reg_wr && reg_addr == `ACZ_REG_CTRL) begin
                soft_cal_q <= reg_wdata[`ACZ_CTRL_SOFT_CAL];
                conv_en_q <= reg_wdata[`ACZ_CTRL_CONV_EN];
            end
            if (reg_wr && reg_addr == `ACZ_REG_CAL_WORD) begin
                cal_index_q <= reg_wdata[IW-1:0];
            end
        end
    end

    // ==========================================================
    // sequencer
    acz_pkg::acz_state_t state_q;
    logic [PW-1:0] phase_q;
    logic cal_pend_q;
    logic cal_req;
    logic cal_start;
    logic cal_busy;
    logic cal_done;
    logic codes_valid;
    logic [15:0] cal_word;
    logic conv_req;
    logic conv_end;

    assign cal_req = !cal_req_n || soft_cal_q;
    assign conv_req = start_convert && conv_en_q;
    assign conv_end = tick_q && state_q == acz_pkg::ACZ_CONV && phase_q == PW'(HOLD_TICKS + TAIL_TICKS - 1);

    // a request seen at the start edge is the one served; keeping it would run a second cycle
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cal_pend_q <= 1'b0;
        end else if (cal_req && state_q != acz_pkg::ACZ_CAL && !cal_start) begin
            cal_pend_q <= 1'b1;
        end else if (cal_start) begin
            cal_pend_q <= 1'b0;
        end
    end

    always_comb begin
        cal_start = 1'b0;
        if (tick_q) begin
            unique case (state_q)
                acz_pkg::ACZ_IDLE: cal_start = cal_pend_q || cal_req;
                acz_pkg::ACZ_CONV: cal_start = conv_end && (cal_pend_q || cal_req);
                acz_pkg::ACZ_CAL: cal_start = 1'b0;
                acz_pkg::ACZ_RECOVER: cal_start = cal_pend_q || cal_req;
            endcase
        end
        if (state_q == acz_pkg::ACZ_CAL && cal_done && !cal_req_n) begin
            cal_start = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= acz_pkg::ACZ_IDLE;
            phase_q <= '0;
        end else if (cal_start) begin
            state_q <= acz_pkg::ACZ_CAL;
            phase_q <= '0;
        end else begin
            unique case (state_q)
                acz_pkg::ACZ_IDLE: begin
                    if (tick_q && conv_req) begin
                        state_q <= acz_pkg::ACZ_CONV;
                        phase_q <= '0;
                    end
                end
                acz_pkg::ACZ_CONV: begin
                    if (conv_end) begin
                        state_q <= acz_pkg::ACZ_IDLE;
                        phase_q <= '0;
                    end else if (tick_q) begin
                        phase_q <= phase_q + 1'b1;
                    end
                end
                acz_pkg::ACZ_CAL: begin
                    // calibration pin pulses are not looked at here
                    if (cal_done) begin
                        state_q <= acz_pkg::ACZ_RECOVER;
                        phase_q <= '0;
                    end
                end
                acz_pkg::ACZ_RECOVER: begin
                    // start requests are not sampled until the window closes
                    if (tick_q) begin
                        if (phase_q == PW'(RECOVER_TICKS - 1)) begin
                            state_q <= acz_pkg::ACZ_IDLE;
                            phase_q <= '0;
                        end else begin
                            phase_q <= phase_q + 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    acz_cal_engine #(
        .CAL_TICKS(CAL_TICKS),
        .WORDS(CAL_WORDS)
    ) u_cal (
        .clock(clock),
        .sys_rst(sys_rst),
        .tick(tick_q),
        .start(cal_start),
        .trim_sample(trim_sample),
        .rd_index(cal_index_q),
        .busy(cal_busy),
        .done(cal_done),
        .codes_valid(codes_valid),
        .rd_word(cal_word)
    );

    // ==========================================================
    // pins toward the host
    logic [PW-1:0] strobe_cnt_q;
    logic strobe_rise;
    logic strobe_fall;
    logic first_done_q;

    assign strobe_rise = conv_end;
    assign strobe_fall = tick_q && data_strobe_q && strobe_cnt_q == PW'(STROBE_TICKS - 1);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cal_status_q <= 1'b0;
        end else if (cal_start) begin
            cal_status_q <= 1'b1;
        end else if (cal_done) begin
            cal_status_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            hold_cmd_q <= 1'b0;
        end else if (cal_start) begin
            hold_cmd_q <= 1'b0;
        end else if (tick_q && state_q == acz_pkg::ACZ_IDLE && conv_req) begin
            hold_cmd_q <= 1'b1;
        end else if (tick_q && state_q == acz_pkg::ACZ_CONV && phase_q == PW'(HOLD_TICKS - 1)) begin
            hold_cmd_q <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            data_strobe_q <= 1'b0;
            strobe_cnt_q <= '0;
        end else if (strobe_rise) begin
            data_strobe_q <= 1'b1;
            strobe_cnt_q <= '0;
        end else if (strobe_fall) begin
            data_strobe_q <= 1'b0;
        end else if (tick_q && data_strobe_q) begin
            strobe_cnt_q <= strobe_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            first_done_q <= 1'b0;
        end else if (strobe_fall) begin
            first_done_q <= 1'b1;
        end
    end

    // ==========================================================
    // offset nulling and output data
    logic [15:0] code;
    logic [15:0] offset;
    logic offset_valid;
    logic az_armed;

    acz_autozero u_az (
        .clock(clock),
        .sys_rst(sys_rst),
        .strobe_rise(strobe_rise),
        .strobe_fall(strobe_fall),
        .autozero(autozero),
        .first_done(first_done_q),
        .output_format_select(output_format_select),
        .raw(sample_data),
        .code(code),
        .offset_q(offset),
        .offset_valid_q(offset_valid),
        .armed_q(az_armed)
    );

    // ordinary results and the captured offset both land at strobe rise
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            data_out_q <= 16'h0000;
        end else if (strobe_rise) begin
            data_out_q <= code;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cal_count_q <= 32'h0000_0000;
        end else if (cal_done) begin
            cal_count_q <= cal_count_q + 32'h0000_0001;
        end
    end

    // ==========================================================
    // register reads
    logic [31:0] status;

    always_comb begin
        status = 32'h0000_0000;
        status[`ACZ_ST_CAL] = cal_status_q;
        status[`ACZ_ST_CONV] = state_q == acz_pkg::ACZ_CONV;
        status[`ACZ_ST_RECOVER] = state_q == acz_pkg::ACZ_RECOVER;
        status[`ACZ_ST_AZ_VALID] = offset_valid;
        status[`ACZ_ST_AZ_ARMED] = az_armed;
        status[`ACZ_ST_CODES_VALID] = codes_valid && !cal_busy;
        status[`ACZ_ST_FIRST_DONE] = first_done_q;
        status[`ACZ_ST_CAL_PEND] = cal_pend_q;
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata_q <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                `ACZ_REG_CTRL: reg_rdata_q <= {30'h0000_0000, conv_en_q, 1'b0};
                `ACZ_REG_STATUS: reg_rdata_q <= status;
                `ACZ_REG_RESULT: reg_rdata_q <= {16'h0000, data_out_q};
                `ACZ_REG_OFFSET: reg_rdata_q <= {16'h0000, offset};
                `ACZ_REG_CAL_COUNT: reg_rdata_q <= cal_count_q;
                `ACZ_REG_CAL_WORD: reg_rdata_q <= {16'h0000, cal_word};
                default: reg_rdata_q <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_q <= 32'h0000_0000;
        end
    end
endmodule

`default_nettype wire

/* File: acz_ctrl_props.sv */
`default_nettype none
module acz_ctrl_props #(
    parameter int CAL_TICKS = 150000,
    parameter int TICK_DIV = 10,
    parameter int RECOVER_TICKS = 17,
    parameter int HOLD_TICKS = 13,
    parameter int TAIL_TICKS = 7
) (
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // watched ports
    input wire logic cal_req_n,
    input wire logic cal_status_q,
    input wire logic hold_cmd_q,
    input wire logic data_strobe_q,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata_q
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CONV = (HOLD_TICKS + TAIL_TICKS) * TICK_DIV;
    localparam int CONV1 = CONV + 1;
    localparam int CYC = CAL_TICKS * TICK_DIV;
    int cal_run_q;
    int hold_run_q;
    int since_cal_q;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ==========================================================
    // run-length counters
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cal_run_q <= 0;
            hold_run_q <= 0;
            since_cal_q <= 100000;
        end else begin
            cal_run_q <= cal_status_q ? cal_run_q + 1 : 0;
            hold_run_q <= hold_cmd_q ? hold_run_q + 1 : 0;
            since_cal_q <= cal_status_q ? 0 : (since_cal_q < 100000 ? since_cal_q + 1 : since_cal_q);
        end
    end
    cal_start_a: assert property ($fell(cal_req_n) && !cal_status_q |-> ##[1:48] cal_status_q)
        else $error("calibration did not start");
    cal_length_a: assert property ($fell(cal_status_q) |-> cal_run_q % CYC == 1 && cal_run_q > 1)
        else $error("calibration length wrong");
    cal_excl_a: assert property (cal_status_q |-> !hold_cmd_q)
        else $error("conversion during calibration");
    recover_gap_a: assert property ($rose(hold_cmd_q) |-> since_cal_q >= RECOVER_TICKS * TICK_DIV)
        else $error("conversion inside recovery");
    hold_width_a: assert property ($fell(hold_cmd_q) |-> hold_run_q == HOLD_TICKS * TICK_DIV)
        else $error("hold width wrong");
    strobe_pos_a: assert property ($rose(data_strobe_q) |-> $past(hold_cmd_q, CONV) && !$past(hold_cmd_q, CONV1))
        else $error("strobe not at conversion end");
    strobe_width_a: assert property ($rose(data_strobe_q) |-> data_strobe_q [*4] ##1 !data_strobe_q)
        else $error("strobe width wrong");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
        else $error("read data outside read slot");
    cover property ($fell(cal_status_q) && cal_run_q > CYC + 1);
    cover property ($rose(data_strobe_q));
    cover property ($rose(hold_cmd_q) && since_cal_q < 40);
endmodule
`default_nettype wire

/* File: acz_host_model.sv */
`default_nettype none
module acz_host_model (
    // clock
    input wire logic clock,
    // converter outputs
    input wire logic cal_status_q,
    input wire logic hold_cmd_q,
    input wire logic data_strobe_q,
    input wire logic [15:0] data_out_q,
    // control pins
    output logic cal_req_n,
    output logic start_convert,
    output logic autozero,
    output logic output_format_select,
    output logic [15:0] sample_data,
    output logic [15:0] trim_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cal_req_n = 1'b1;
        start_convert = 1'b0;
        autozero = 1'b0;
        output_format_select = 1'b0;
        sample_data = 16'h0000;
        trim_sample = 16'h5A5A;
    end
    // moving trim words so the correction store never sees a constant
    always @(posedge clock) trim_sample <= trim_sample + 16'h0001;
    // ==========================================================
    // host actions
    task automatic pulse_cal(input int n);
        @(posedge clock);
        cal_req_n <= 1'b0;
        repeat (n) @(posedge clock);
        cal_req_n <= 1'b1;
    endtask
    task automatic convert(input logic [15:0] v, input logic [1:0] fa, output logic [15:0] seen);
        int i;
        @(posedge clock);
        for (i = 0; i < 300 && cal_status_q; i++) @(posedge clock);
        sample_data <= v;
        output_format_select <= fa[1];
        autozero <= fa[0];
        start_convert <= 1'b1;
        for (i = 0; i < 300 && !hold_cmd_q; i++) @(posedge clock);
        start_convert <= 1'b0;
        for (i = 0; i < 300 && !data_strobe_q; i++) @(posedge clock);
        seen = data_out_q;
        for (i = 0; i < 10 && data_strobe_q; i++) @(posedge clock);
    endtask
endmodule
`default_nettype wire

/* File: acz_map.svh */
`ifndef ACZ_MAP_SVH
`define ACZ_MAP_SVH

// ==========================================================
// clocking
`define ACZ_SYS_CLK_HZ 100000000
`define ACZ_CONV_CLK_HZ 10000000
`define ACZ_TICK_DIV (`ACZ_SYS_CLK_HZ / `ACZ_CONV_CLK_HZ)

// ==========================================================
// timing, in conversion clock periods; calibration time in microseconds
`define ACZ_CAL_TIME_US 15000
`define ACZ_CAL_TICKS (`ACZ_CAL_TIME_US * (`ACZ_CONV_CLK_HZ / 1000000))
`define ACZ_RECOVER_TICKS 17
`define ACZ_HOLD_TICKS 13
`define ACZ_TAIL_TICKS 7
`define ACZ_STROBE_TICKS 2
`define ACZ_CAL_WORDS 16

// ==========================================================
// register offsets
`define ACZ_REG_CTRL 8'h00
`define ACZ_REG_STATUS 8'h04
`define ACZ_REG_RESULT 8'h08
`define ACZ_REG_OFFSET 8'h0C
`define ACZ_REG_CAL_COUNT 8'h10
`define ACZ_REG_CAL_WORD 8'h14

// ==========================================================
// field positions
`define ACZ_CTRL_SOFT_CAL 0
`define ACZ_CTRL_CONV_EN 1
`define ACZ_CTRL_RESET 32'h0000_0002
`define ACZ_ST_CAL 0
`define ACZ_ST_CONV 1
`define ACZ_ST_RECOVER 2
`define ACZ_ST_AZ_VALID 3
`define ACZ_ST_AZ_ARMED 4
`define ACZ_ST_CODES_VALID 5
`define ACZ_ST_FIRST_DONE 6
`define ACZ_ST_CAL_PEND 7

// ==========================================================
// data codes
`define ACZ_MIDSCALE 17'h08000
`define ACZ_POS_MAX 17'h07FFF
`define ACZ_NEG_MIN 17'h18000

`endif

/* File: acz_pkg.sv */
`default_nettype none

package acz_pkg;
    typedef enum logic [1:0] {
        ACZ_IDLE,
        ACZ_CONV,
        ACZ_CAL,
        ACZ_RECOVER
    } acz_state_t;
endpackage

`default_nettype wire

/* File: test_adc_calibration_autozero_control.sv */
`include "acz_map.svh"
`default_nettype none
module test_adc_calibration_autozero_control;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, sys_rst, cal_req_n, start_convert, autozero, output_format_select;
    logic cal_status_q, hold_cmd_q, data_strobe_q, reg_wr, reg_rd;
    logic [15:0] sample_data, trim_sample, data_out_q, seen;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata_q, rv;
    int miscompares, compares, cycles, n, k, i;
    // sample, format and autozero, expected code
    logic [33:0] tab [8] = '{{16'h0123, 2'b00, 16'hFEDC}, {16'h0123, 2'b01, 16'hFEDC},
        {16'h0123, 2'b01, 16'hFFFF}, {16'h0123, 2'b11, 16'h8000}, {16'h8000, 2'b01, 16'h7FFF},
        {16'h8000, 2'b11, 16'hFFFF}, {16'h7FFF, 2'b11, 16'h0124}, {16'h0123, 2'b00, 16'hFEDC}};
    acz_ctrl #(.CAL_TICKS(50), .TICK_DIV(2)) dut (.clock(clock), .sys_rst(sys_rst), .cal_req_n(cal_req_n),
        .start_convert(start_convert), .autozero(autozero), .output_format_select(output_format_select),
        .sample_data(sample_data), .trim_sample(trim_sample), .cal_status_q(cal_status_q),
        .hold_cmd_q(hold_cmd_q), .data_strobe_q(data_strobe_q), .data_out_q(data_out_q),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
    acz_host_model m (.clock(clock), .cal_status_q(cal_status_q), .hold_cmd_q(hold_cmd_q),
        .data_strobe_q(data_strobe_q), .data_out_q(data_out_q), .cal_req_n(cal_req_n),
        .start_convert(start_convert), .autozero(autozero), .output_format_select(output_format_select),
        .sample_data(sample_data), .trim_sample(trim_sample));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ==========================================================
    // bench tasks
    task automatic check(input string name, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(negedge clock);
        d = reg_rdata_q;
    endtask
    task automatic cal_run(output int len);
        int j;
        len = 0;
        for (j = 0; j < 300 && cal_status_q !== 1'b1; j++) @(posedge clock);
        while (cal_status_q === 1'b1 && len < 1000) begin
            @(posedge clock);
            len++;
        end
    endtask
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            end_sim();
        end
    end
    initial begin
        {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 8'h00, 32'h0};
        {miscompares, compares, cycles} = '0;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        rd(`ACZ_REG_CTRL, rv); check("ctrl", rv, `ACZ_CTRL_RESET);
        rd(`ACZ_REG_STATUS, rv); check("status", rv, 32'h0);
        wr(`ACZ_REG_STATUS, 32'hFFFF_FFFF);
        rd(`ACZ_REG_STATUS, rv); check("status ro", rv, 32'h0);
        rd(8'hFC, rv); check("unmapped", rv, 32'h0);
        fork m.pulse_cal(2); cal_run(n); join
        check("cal len", n, 101);
        k = 0;
        fork
            m.convert(16'h0000, 2'b00, seen);
            while (!hold_cmd_q && k < 200) begin @(posedge clock); k++; end
        join
        check("recovery", k >= 34 && k <= 40, 1);
        check("zero code", seen, 16'hFFFF);
        rd(`ACZ_REG_STATUS, rv); check("codes valid", rv[`ACZ_ST_CODES_VALID], 1);
        for (i = 0; i < 8; i++) begin
            m.convert(tab[i][33:18], tab[i][17:16], seen);
            check("az code", seen, tab[i][15:0]);
            if (i == 3) begin rd(`ACZ_REG_OFFSET, rv); check("offset", rv, 32'h123); end
        end
        fork m.pulse_cal(2); cal_run(n); begin repeat (30) @(posedge clock); m.pulse_cal(3); end join
        check("ignored pulse", n, 101);
        fork m.pulse_cal(150); cal_run(n); join
        check("held", n, 201);
        fork wr(`ACZ_REG_CTRL, 32'h3); cal_run(n); join
        check("soft cal", n, 101);
        fork
            m.convert(16'h0123, 2'b00, seen);
            begin
                for (k = 0; k < 300 && !hold_cmd_q; k++) @(posedge clock);
                m.pulse_cal(2);
                check("pending", cal_status_q, 0);
            end
        join
        check("conv data", seen, 16'hFEDC);
        check("cal after conv", cal_status_q, 1);
        for (k = 0; k < 300 && cal_status_q; k++) @(posedge clock);
        rd(`ACZ_REG_CAL_COUNT, rv); check("cal count", rv, 32'h6);
        end_sim();
    end
endmodule
bind acz_ctrl acz_ctrl_props #(.CAL_TICKS(CAL_TICKS), .TICK_DIV(TICK_DIV)) props (.clock(clock), .sys_rst(sys_rst),
    .cal_req_n(cal_req_n), .cal_status_q(cal_status_q), .hold_cmd_q(hold_cmd_q),
    .data_strobe_q(data_strobe_q), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));
`default_nettype wire
